// File: pkg/jbm_defines.svh
`ifndef JBM_DEFINES_SVH
`define JBM_DEFINES_SVH

// register offsets
`define JBM_REG_RX_FIRST 8'h15
`define JBM_REG_RX_LAST 8'h1C
`define JBM_REG_MODE 8'h2A
`define JBM_REG_NODE_ADDR 8'h2B
`define JBM_REG_FUNC_ADDR 8'h2C
`define JBM_REG_RX_LEN 8'h2D
`define JBM_REG_IRQ 8'h2E
`define JBM_REG_IE 8'h2F
`define JBM_REG_FAULT 8'h30
`define JBM_REG_OVF_BYTE 8'h3C

// fields and reset values
`define JBM_DIV_MSB 7
`define JBM_DIV_LSB 5
`define JBM_DIV_ENTRY 3'h7
`define JBM_ENTRY_PULSES 3'h4
`define JBM_MON_BIT 0
`define JBM_MODE_RST 8'h00
`define JBM_ADDR_RST 8'h00
`define JBM_RX_BYTES 8
`define JBM_FIFO_DEPTH 8

// timing
`define JBM_CLK_PERIOD_NS 4
`define JBM_SHORT_DET_NS 5000
`define JBM_LONG_DET_NS 48000
`define JBM_SHORT_DET_CYC \
  ((`JBM_SHORT_DET_NS + `JBM_CLK_PERIOD_NS - 1) / `JBM_CLK_PERIOD_NS)
`define JBM_LONG_DET_CYC \
  ((`JBM_LONG_DET_NS + `JBM_CLK_PERIOD_NS - 1) / `JBM_CLK_PERIOD_NS)
`define JBM_DET_CNT_W 14

`endif

// File: pkg/jbm_pkg.sv
package jbm_pkg;

  typedef struct packed {
    logic sof;
    logic eof;
    logic [7:0] data;
  } jbm_rxw_s;

  typedef enum logic [1:0] {
    JBM_IDLE = 2'h0,
    JBM_RECV = 2'h1,
    JBM_DROP = 2'h2
  } jbm_rx_state_e;

  typedef struct packed {
    logic [1:0] sync;
    logic [13:0] cnt;
    logic flag;
  } jbm_filt_s;

  typedef struct packed {
    logic [2:0] ale_q;
    logic [2:0] cs_q;
    logic [2:0] rd_q;
    logic [2:0] wr_q;
    logic [1:0][7:0] ad_q;
    logic [7:0] addr_r;
    logic [7:0] mode_r;
    logic [7:0] node_addr_r;
    logic [7:0] func_addr_r;
    logic [2:0] entry_cnt_r;
    logic monitor_r;
    logic [8:0][7:0] rx_r;
    logic [7:0] rx_len_r;
    logic rx_full_r;
    logic mon_irq_r;
    logic mon_ie_r;
    logic [7:0] rd_data_r;
    logic rd_oe_r;
    jbm_rx_state_e st_r;
    logic [7:0] cnt_r;
    logic own_hit_r;
    logic ifr_r;
  } jbm_state_s;

endpackage : jbm_pkg

// File: core/jbm_fifo.sv
`timescale 1ns/1ps
module jbm_fifo #(
  parameter int WIDTH = 10,
  parameter int DEPTH = 8
) (
  input wire logic i_clock,
  input wire logic i_sys_rst,
  input wire logic i_in_valid,
  output logic o_in_ready,
  input wire logic [WIDTH-1:0] i_in_data,
  output logic o_out_valid,
  input wire logic i_out_ready,
  output logic [WIDTH-1:0] o_out_data
);
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] level;
  } jbm_fifo_s;

  jbm_fifo_s s_r;
  jbm_fifo_s s_nxt;
  logic push;
  logic pop;

  // full and empty come straight from the level count
  assign o_in_ready = (s_r.level != (AW+1)'(DEPTH));
  assign o_out_valid = (s_r.level != '0);
  assign o_out_data = s_r.mem[s_r.rp];
  assign push = i_in_valid && o_in_ready;
  assign pop = o_out_valid && i_out_ready;

  always_comb begin
    s_nxt = s_r;
    if (push) begin
      s_nxt.mem[s_r.wp] = i_in_data;
      s_nxt.wp = (s_r.wp == AW'(DEPTH - 1)) ? '0 : s_r.wp + 1'b1;
    end
    if (pop) begin
      s_nxt.rp = (s_r.rp == AW'(DEPTH - 1)) ? '0 : s_r.rp + 1'b1;
    end
    s_nxt.level = s_r.level + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end
endmodule : jbm_fifo

// File: core/jbm_short_filter.sv
`timescale 1ns/1ps
`include "jbm_defines.svh"
module jbm_short_filter import jbm_pkg::*; #(
  parameter logic [`JBM_DET_CNT_W-1:0] THRESHOLD = 14'h04E2
) (
  input wire logic i_clock,
  input wire logic i_sys_rst,
  input wire logic i_fault_pin,
  output logic o_flag
);
  jbm_filt_s s_r;
  jbm_filt_s s_nxt;

  // a fault level must persist without a break; any gap restarts it
  always_comb begin
    s_nxt = s_r;
    s_nxt.sync = {s_r.sync[0], i_fault_pin};
    if (!s_r.sync[1]) begin
      s_nxt.cnt = '0;
      s_nxt.flag = 1'b0;
    end else if (s_r.cnt < THRESHOLD) begin
      s_nxt.cnt = s_r.cnt + 1'b1;
    end else begin
      s_nxt.flag = 1'b1;
    end
  end

  assign o_flag = s_r.flag;

  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end
endmodule : jbm_short_filter

// File: core/jbm_monitor_rx.sv
`timescale 1ns/1ps
`include "jbm_defines.svh"
module jbm_monitor_rx import jbm_pkg::*; #(
  parameter int LONG_DET_CYC = `JBM_LONG_DET_CYC
) (
  input wire logic i_clock,
  input wire logic i_sys_rst,
  input wire logic i_ale,
  input wire logic i_cs_n,
  input wire logic i_rd_n,
  input wire logic i_wr_n,
  input wire logic [7:0] i_ad,
  output logic [7:0] o_ad,
  output logic o_ad_oe_n,
  input wire logic i_rx_valid,
  output logic o_rx_ready,
  input wire logic [7:0] i_rx_data,
  input wire logic i_rx_sof,
  input wire logic i_rx_eof,
  input wire logic [3:0] i_short_pin,
  output logic [3:0] o_short,
  output logic o_ifr_request,
  output logic o_monitor_mode,
  output logic o_monitor_event
);
  ////////////////////////////////////////////////////////////////////////
  localparam logic [`JBM_DET_CNT_W-1:0] SHORT_TH =
    `JBM_DET_CNT_W'(`JBM_SHORT_DET_CYC);
  localparam logic [`JBM_DET_CNT_W-1:0] LONG_TH =
    `JBM_DET_CNT_W'(LONG_DET_CYC);

  jbm_state_s s_r;
  jbm_state_s s_nxt;
  jbm_rxw_s fifo_in;
  jbm_rxw_s fifo_out;
  logic fifo_valid;
  logic fifo_pop_ready;
  logic [3:0] short_flags;

  ////////////////////////////////////////////////////////////////////////
  // pin 0 pos-gnd, 1 pos-supply, 2 neg-gnd, 3 neg-supply
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_short
      jbm_short_filter #(
        .THRESHOLD((gi == 0 || gi == 3) ? SHORT_TH : LONG_TH)
      ) u_filt (
        .i_clock(i_clock),
        .i_sys_rst(i_sys_rst),
        .i_fault_pin(i_short_pin[gi]),
        .o_flag(short_flags[gi])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  assign fifo_in = '{sof: i_rx_sof, eof: i_rx_eof, data: i_rx_data};
  // draining stops while an unread frame sits in the buffer
  assign fifo_pop_ready = !s_r.rx_full_r;

  jbm_fifo #(
    .WIDTH($bits(jbm_rxw_s)),
    .DEPTH(`JBM_FIFO_DEPTH)
  ) u_fifo (
    .i_clock(i_clock),
    .i_sys_rst(i_sys_rst),
    .i_in_valid(i_rx_valid),
    .o_in_ready(o_rx_ready),
    .i_in_data(fifo_in),
    .o_out_valid(fifo_valid),
    .i_out_ready(fifo_pop_ready),
    .o_out_data(fifo_out)
  );

  ////////////////////////////////////////////////////////////////////////
  logic ale_fall;
  logic rd_fall;
  logic wr_rise;
  logic cs_act;
  logic rd_act;
  logic pop;
  logic irq_clr;
  logic [7:0] wdata;
  logic [7:0] rmux;
  logic [3:0] idx;
  logic own_match;
  logic any_match;

  always_comb begin
    s_nxt = s_r;
    // second stage feeds only the third and the decode below
    s_nxt.ale_q = {s_r.ale_q[1:0], i_ale};
    s_nxt.cs_q = {s_r.cs_q[1:0], i_cs_n};
    s_nxt.rd_q = {s_r.rd_q[1:0], i_rd_n};
    s_nxt.wr_q = {s_r.wr_q[1:0], i_wr_n};
    s_nxt.ad_q = {s_r.ad_q[0], i_ad};
    cs_act = !s_r.cs_q[1];
    rd_act = cs_act && !s_r.rd_q[1];
    ale_fall = s_r.ale_q[2] && !s_r.ale_q[1];
    rd_fall = s_r.rd_q[2] && !s_r.rd_q[1] && cs_act;
    wr_rise = !s_r.wr_q[2] && s_r.wr_q[1] && cs_act;
    wdata = s_r.ad_q[1];
    irq_clr = 1'b0;
    s_nxt.ifr_r = 1'b0;

    // address latch and mode entry pulses
    if (ale_fall) begin
      s_nxt.addr_r = wdata;
    end
    if (s_r.mode_r[`JBM_DIV_MSB:`JBM_DIV_LSB] != `JBM_DIV_ENTRY) begin
      s_nxt.entry_cnt_r = '0;
    end else if (ale_fall && cs_act) begin
      if (s_r.entry_cnt_r == `JBM_ENTRY_PULSES - 3'h1) begin
        s_nxt.monitor_r = 1'b1;
        s_nxt.entry_cnt_r = '0;
      end else begin
        s_nxt.entry_cnt_r = s_r.entry_cnt_r + 3'h1;
      end
    end

    // host writes
    if (wr_rise) begin
      case (s_r.addr_r)
        `JBM_REG_MODE: s_nxt.mode_r = wdata;
        `JBM_REG_NODE_ADDR: s_nxt.node_addr_r = wdata;
        `JBM_REG_FUNC_ADDR: s_nxt.func_addr_r = wdata;
        `JBM_REG_IRQ: irq_clr = wdata[`JBM_MON_BIT];
        `JBM_REG_IE: s_nxt.mon_ie_r = wdata[`JBM_MON_BIT];
        default: begin
        end
      endcase
    end

    // host read mux
    idx = 4'(s_r.addr_r - `JBM_REG_RX_FIRST);
    case (s_r.addr_r)
      `JBM_REG_MODE: rmux = s_r.mode_r;
      `JBM_REG_NODE_ADDR: rmux = s_r.node_addr_r;
      `JBM_REG_FUNC_ADDR: rmux = s_r.func_addr_r;
      `JBM_REG_RX_LEN: rmux = s_r.rx_len_r;
      `JBM_REG_IRQ: rmux = {7'h00, s_r.mon_irq_r && s_r.monitor_r};
      `JBM_REG_IE: rmux = {7'h00, s_r.mon_ie_r};
      `JBM_REG_FAULT: rmux = {4'h0, short_flags};
      `JBM_REG_OVF_BYTE: rmux = s_r.rx_r[8];
      default: begin
        if (s_r.addr_r >= `JBM_REG_RX_FIRST &&
            s_r.addr_r <= `JBM_REG_RX_LAST) begin
          rmux = s_r.rx_r[idx];
        end else begin
          rmux = 8'h00;
        end
      end
    endcase
    if (rd_fall) begin
      s_nxt.rd_data_r = rmux;
      // reading the length hands the buffer back to the receiver
      if (s_r.addr_r == `JBM_REG_RX_LEN) begin
        s_nxt.rx_full_r = 1'b0;
      end
    end
    s_nxt.rd_oe_r = rd_act;

    // frame capture
    pop = fifo_valid && fifo_pop_ready;
    own_match = (fifo_out.data == s_r.node_addr_r);
    any_match = own_match || (fifo_out.data == s_r.func_addr_r);
    if (irq_clr) begin
      s_nxt.mon_irq_r = 1'b0;
    end
    if (pop) begin
      if (fifo_out.sof || s_r.st_r == JBM_RECV) begin
        if (fifo_out.sof) begin
          s_nxt.cnt_r = 8'h01;
          s_nxt.own_hit_r = 1'b0;
          s_nxt.st_r = JBM_RECV;
          s_nxt.rx_r[0] = fifo_out.data;
        end else begin
          s_nxt.cnt_r = (s_r.cnt_r == 8'hFF) ? 8'hFF : s_r.cnt_r + 8'h01;
          if (s_r.cnt_r < 8'(`JBM_RX_BYTES)) begin
            s_nxt.rx_r[s_r.cnt_r[3:0]] = fifo_out.data;
          end else if (s_r.cnt_r == 8'(`JBM_RX_BYTES) &&
                       s_r.monitor_r) begin
            s_nxt.rx_r[8] = fifo_out.data;
          end
          // second header byte is the target address
          if (s_r.cnt_r == 8'h01) begin
            s_nxt.own_hit_r = own_match;
            if (!s_r.monitor_r && !any_match) begin
              s_nxt.st_r = JBM_DROP;
            end
          end
        end
        if (fifo_out.eof && s_nxt.st_r == JBM_RECV) begin
          s_nxt.st_r = JBM_IDLE;
          s_nxt.rx_full_r = 1'b1;
          s_nxt.ifr_r = s_nxt.own_hit_r;
          if (s_r.monitor_r) begin
            s_nxt.rx_len_r = s_nxt.cnt_r;
            s_nxt.mon_irq_r = 1'b1;
          end else begin
            // normal frames drop the trailing CRC from the count
            s_nxt.rx_len_r = s_nxt.cnt_r - 8'h01;
          end
        end
      end else if (s_r.st_r == JBM_DROP && fifo_out.eof) begin
        s_nxt.st_r = JBM_IDLE;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  assign o_ad = s_r.rd_data_r;
  assign o_ad_oe_n = !s_r.rd_oe_r;
  assign o_short = short_flags;
  assign o_ifr_request = s_r.ifr_r;
  assign o_monitor_mode = s_r.monitor_r;
  assign o_monitor_event =
    s_r.mon_irq_r && s_r.monitor_r && s_r.mon_ie_r;

  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      s_r <= '0;
      s_r.ale_q <= 3'h0;
      s_r.cs_q <= 3'h7;
      s_r.rd_q <= 3'h7;
      s_r.wr_q <= 3'h7;
      s_r.mode_r <= `JBM_MODE_RST;
      s_r.node_addr_r <= `JBM_ADDR_RST;
      s_r.func_addr_r <= `JBM_ADDR_RST;
      s_r.st_r <= JBM_IDLE;
    end else begin
      s_r <= s_nxt;
    end
  end
endmodule : jbm_monitor_rx

// File: testbench/jbm_mon_properties.sv
`timescale 1ns/1ps
module jbm_mon_properties #(
  parameter int LONG_DET_CYC = 12000
) (
  input wire logic i_clock,
  input wire logic i_sys_rst,
  input wire logic i_cs_n,
  input wire logic i_rd_n,
  input wire logic [7:0] o_ad,
  input wire logic o_ad_oe_n,
  input wire logic [3:0] i_short_pin,
  input wire logic [3:0] o_short,
  input wire logic o_ifr_request,
  input wire logic o_monitor_mode,
  input wire logic o_monitor_event
);
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_sys_rst);
  // consecutive cycles each fault pin has been high, saturating
  logic [3:0][15:0] held_r;
  logic [3:0][15:0] held_nxt;
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      held_nxt[i] = i_short_pin[i] ? held_r[i] + 16'h0001 : 16'h0000;
      if (held_r[i] == 16'hffff) held_nxt[i] = held_r[i];
    end
  end
  always_ff @(posedge i_clock) held_r <= i_sys_rst ? '0 : held_nxt;
  ////////////////////////////////////////
  sequence rd_held;
    (!i_cs_n && !i_rd_n) [*5];
  endsequence
  sequence rd_idle;
    i_rd_n [*5];
  endsequence
  a_read_drives:
    assert property (rd_held |-> !o_ad_oe_n)
    else $error("read strobe did not enable the data driver");
  a_idle_floats:
    assert property (rd_idle |-> o_ad_oe_n)
    else $error("data driver enabled without a read");
  a_data_holds:
    assert property ((!i_rd_n) [*8] |=> $stable(o_ad))
    else $error("read data changed during a held read");
  a_mode_sticky:
    assert property (o_monitor_mode |=> o_monitor_mode)
    else $error("monitor mode dropped without reset");
  a_event_mode:
    assert property (o_monitor_event |-> o_monitor_mode)
    else $error("monitor event outside monitor mode");
  a_ifr_single:
    assert property (o_ifr_request |=> !o_ifr_request)
    else $error("response request longer than one cycle");
  for (genvar g = 0; g < 4; g++) begin : g_short
    // lines 1 and 2 use the long persistence, 0 and 3 the short one
    localparam int THR = (g == 1 || g == 2) ? LONG_DET_CYC : 1250;
    a_short_early:
      assert property ($rose(o_short[g]) |-> held_r[g] >= THR)
      else $error("short flagged before the fault persisted");
    a_short_late:
      assert property (held_r[g] >= THR + 8 |-> o_short[g])
      else $error("persistent short not flagged");
  end
endmodule : jbm_mon_properties

bind jbm_monitor_rx jbm_mon_properties #(.LONG_DET_CYC(LONG_DET_CYC)) u_props (
  .i_clock, .i_sys_rst, .i_cs_n, .i_rd_n, .o_ad, .o_ad_oe_n, .i_short_pin,
  .o_short, .o_ifr_request, .o_monitor_mode, .o_monitor_event);

// File: testbench/jbm_bus_node.sv
`timescale 1ns/1ps
module jbm_bus_node (
  input wire logic i_clock,
  input wire logic i_rx_ready,
  output logic o_rx_valid,
  output logic [7:0] o_rx_data,
  output logic o_rx_sof,
  output logic o_rx_eof
);
  initial begin
    o_rx_valid = 1'b0;
    o_rx_data = 8'h00;
    o_rx_sof = 1'b0;
    o_rx_eof = 1'b0;
  end
  // between bytes the data shows the inverse, so stale bytes never match
  // ready is sampled mid-cycle, before the edge that takes the byte, so a
  // push that fills the buffer is never mistaken for a refusal and repeated
  task automatic send(input logic [7:0] f[$], input int gap);
    logic took;
    for (int i = 0; i < f.size(); i++) begin
      o_rx_valid <= 1'b1;
      o_rx_data <= f[i];
      o_rx_sof <= (i == 0);
      o_rx_eof <= (i == f.size() - 1);
      do begin
        @(negedge i_clock);
        took = (i_rx_ready === 1'b1);
        @(posedge i_clock);
      end while (!took);
      if (gap > 0 || i == f.size() - 1) begin
        o_rx_valid <= 1'b0;
        o_rx_data <= ~f[i];
        repeat (gap) @(posedge i_clock);
      end
    end
    @(posedge i_clock);
  endtask : send
endmodule : jbm_bus_node

// File: testbench/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  logic i_clock = 0, i_sys_rst = 1, ale = 0, cs_n = 1, rd_n = 1, wr_n = 1;
  logic [7:0] ad = 8'h00, o_ad, rx_data;
  logic [3:0] short_pin = 4'h0, o_short;
  logic o_ad_oe_n, rx_valid, rx_ready, rx_sof, rx_eof, ifr, mon, ev;
  logic seen_ifr = 0;
  int errors = 0, checks = 0, cycles = 0;
  logic [7:0] fr[$];
  always #2 i_clock = ~i_clock;
  jbm_monitor_rx #(.LONG_DET_CYC(40)) DUT (.i_clock, .i_sys_rst,
    .i_ale(ale), .i_cs_n(cs_n), .i_rd_n(rd_n), .i_wr_n(wr_n), .i_ad(ad),
    .o_ad, .o_ad_oe_n, .i_rx_valid(rx_valid), .o_rx_ready(rx_ready),
    .i_rx_data(rx_data), .i_rx_sof(rx_sof), .i_rx_eof(rx_eof),
    .i_short_pin(short_pin), .o_short, .o_ifr_request(ifr),
    .o_monitor_mode(mon), .o_monitor_event(ev));
  jbm_bus_node node (.i_clock, .i_rx_ready(rx_ready), .o_rx_valid(rx_valid),
    .o_rx_data(rx_data), .o_rx_sof(rx_sof), .o_rx_eof(rx_eof));
  always @(posedge i_clock) if (ifr === 1'b1) seen_ifr <= 1'b1;
  ////////////////////////////////////////
  task automatic test_done;
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : test_done
  // long enough for every test; a stuck handshake ends here
  always @(posedge i_clock) begin
    cycles++;
    if (cycles == 20000) begin
      errors++;
      test_done();
    end
  end
  task automatic tick(input int n);
    repeat (n) @(posedge i_clock);
  endtask : tick
  task automatic check(input string what, input logic [7:0] seen,
                       input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  // pin strobes pass two synchroniser stages, so each level stands 4 clocks
  task automatic latch(input logic [7:0] a);
    cs_n <= 0; ale <= 1; ad <= a; tick(4);
    ale <= 0; tick(4);
  endtask : latch
  task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
    latch(a);
    ad <= d; wr_n <= 0; tick(4);
    wr_n <= 1; tick(4);
    cs_n <= 1; ad <= ~d; tick(4);
  endtask : reg_write
  task automatic expect_reg(input logic [7:0] a, input logic [7:0] exp);
    latch(a);
    ad <= ~a; rd_n <= 0; tick(9);
    check($sformatf("reg %h", a), o_ad, exp);
    rd_n <= 1; tick(1);
    cs_n <= 1; tick(4);
  endtask : expect_reg
  task automatic expect_frame(input logic [7:0] f[$]);
    for (int i = 0; i < 8 && i < f.size(); i++) expect_reg(8'h15 + 8'(i), f[i]);
    if (f.size() == 9) expect_reg(8'h3c, f[8]);
  endtask : expect_frame
  ////////////////////////////////////////
  initial begin
    tick(12);
    i_sys_rst <= 0; tick(4);
    expect_reg(8'h2e, 8'h00);
    reg_write(8'h2f, 8'h01);
    expect_reg(8'h2f, 8'h01);
    expect_reg(8'h40, 8'h00);
    $display("test registers done");
    reg_write(8'h2b, 8'h10);
    fr = '{8'h68, 8'h55, 8'hf1, 8'h01, 8'h7a};
    node.send(fr, 0);
    fr = '{8'h68, 8'h10, 8'hf1, 8'hab, 8'hcc};
    node.send(fr, 0);
    tick(8);
    expect_frame(fr[0:3]);
    expect_reg(8'h2d, 8'h04);
    check("event normal", ev, 8'h00);
    $display("test filter done");
    reg_write(8'h2a, 8'he0);
    repeat (4) latch(8'h00);
    cs_n <= 1; tick(4);
    check("monitor mode", mon, 8'h01);
    reg_write(8'h2a, 8'h20);
    reg_write(8'h2b, 8'h10);
    seen_ifr <= 0;
    fr = '{8'h68, 8'h55, 8'hf1, 8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h9e};
    node.send(fr, 2);
    tick(8);
    check("no response", seen_ifr, 8'h00);
    check("event", ev, 8'h01);
    expect_reg(8'h2e, 8'h01);
    expect_frame(fr);
    expect_reg(8'h2d, 8'h09);
    reg_write(8'h2e, 8'h01);
    check("event cleared", ev, 8'h00);
    $display("test monitor done");
    fr = '{8'h68, 8'h10, 8'hf1};
    node.send(fr, 0);
    fr = '{8'h68, 8'h22, 8'hf1, 8'h11, 8'h12, 8'h13, 8'h14, 8'h15, 8'h5d};
    fork
      node.send(fr, 0);
    join_none
    tick(20);
    check("buffer full", rx_ready, 8'h00);
    check("response", seen_ifr, 8'h01);
    expect_reg(8'h2d, 8'h03);
    wait fork;
    tick(8);
    expect_frame(fr);
    expect_reg(8'h2d, 8'h09);
    $display("test buffer done");
    short_pin <= 4'hf; tick(30);
    check("short early", {4'h0, o_short}, 8'h00);
    tick(30);
    check("short long", {4'h0, o_short}, 8'h06);
    tick(1230);
    check("short all", {4'h0, o_short}, 8'h0f);
    expect_reg(8'h30, 8'h0f);
    short_pin <= 4'h0; tick(8);
    check("short gone", {4'h0, o_short}, 8'h00);
    $display("test shorts done");
    test_done();
  end
endmodule : tb_top
